/* File: rtl/rtc_port_pkg.sv */
// Constants and carrier types for the clock access port
package rtc_port_pkg;
	localparam logic [7:0] SFR_ADR_CTL = 8'h00AC;
	localparam logic [7:0] SFR_DATA = 8'h00AD;
	localparam logic [7:0] SFR_KEY = 8'h00AE;
	localparam logic [7:0] KEY_FIRST = 8'h00A5;
	localparam logic [7:0] KEY_SECOND = 8'h00F1;
	localparam logic [7:0] ST_LOCKED = 8'h0000;
	localparam logic [7:0] ST_FIRST = 8'h0001;
	localparam logic [7:0] ST_UNLOCKED = 8'h0002;
	localparam logic [7:0] ST_DISABLED = 8'h0003;
	localparam int BIT_BUSY = 7;
	localparam int BIT_AUTO_READ_ENABLE = 6;
	localparam int BIT_VREG = 5;
	localparam int BIT_SHORT = 4;
	localparam logic [3:0] SEL_LAST_AUTOINC = 4'h000D;
	localparam logic [3:0] SEL_CAPTURE_LAST = 4'h5;
	localparam logic [3:0] SEL_ALARM_FIRST = 4'h8;
	localparam logic [1:0] STROBE_LONG_LAST = 2'h3;
	localparam logic [1:0] STROBE_SHORT_LAST = 2'h0;
	localparam logic [7:0] RDATA_RESET = 8'h0000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MISSING_TIME_NS = 50000;
	localparam logic [9:0] MISSING_CYCLES =
		10'((MISSING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
	} int_req_type;

	typedef struct packed {
		logic clock_fail_set;
		logic wake_request;
		logic clock_irq;
		logic reset_request;
	} osc_event_type;
endpackage

/* File: rtl/rtc_locked_indirect_port.sv */
// Locked indirect access port and missing clock detector of the clock
`timescale 1ns/100ps
`default_nettype none

module rtc_locked_indirect_port (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output rtc_port_pkg::int_req_type int_req,
	input wire logic [7:0] int_rdata,
	input wire logic int_ack,
	input wire logic backup_above_core,
	output logic backup_regulator_force,
	input wire logic slow_osc_clock,
	input wire logic missing_clock_enable,
	input wire logic irq_enable,
	input wire logic reset_source_enable,
	output rtc_port_pkg::osc_event_type osc_event
);
	import rtc_port_pkg::*;

	typedef enum logic [1:0] {LOCKED, FIRST_KEY, UNLOCKED, DISABLED} lock_type;
	typedef enum logic [1:0] {X_IDLE, X_REQ, X_DROP} xfer_type;

	// Reset enters at once but leaves on the clock, so no flop sees a runt release
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire logic rst_n = rst_sync_r;

	// Bus decode
	wire logic hit_adr = sfr_addr == SFR_ADR_CTL;
	wire logic hit_dat = sfr_addr == SFR_DATA;
	wire logic hit_key = sfr_addr == SFR_KEY;
	wire logic key_wr = sfr_wr && hit_key;
	wire logic adr_wr = sfr_wr && hit_adr;
	wire logic dat_wr = sfr_wr && hit_dat;
	wire logic dat_rd = sfr_rd && hit_dat;
	wire logic port_access = (sfr_wr || sfr_rd) && (hit_adr || hit_dat);

	lock_type lock_r;
	lock_type lock_nxt;
	xfer_type xfer_r;
	xfer_type xfer_nxt;

	wire logic unlocked = lock_r == UNLOCKED;
	wire logic busy = xfer_r != X_IDLE;

	// Held through device reset
	logic [3:0] sel_r;
	logic auto_read_enable_r;
	logic short_r;
	logic [7:0] data_r;
	logic vreg_r;

	// Access before unlock, or data access mid-transfer, is invalid
	wire logic bad_access = port_access && (!unlocked || (hit_dat && busy));
	wire logic ok_access = port_access && !bad_access;

	wire logic start_rd = ok_access && !busy && ((adr_wr && sfr_wdata[BIT_BUSY])
		|| (dat_rd && auto_read_enable_r));
	wire logic start_wr = ok_access && dat_wr && !busy;
	// A busy write that also moves the field reads from the new target
	wire logic [3:0] req_sel = adr_wr ? sfr_wdata[3:0] : sel_r;

	// Lock state machine; key writes step it, and a bad port access, read or write, disables it
	always_comb begin
		lock_nxt = lock_r;
		case (lock_r)
			LOCKED: begin
				if (key_wr) begin
					lock_nxt = (sfr_wdata == KEY_FIRST) ? FIRST_KEY : DISABLED;
				end
			end
			FIRST_KEY: begin
				if (key_wr) begin
					lock_nxt = (sfr_wdata == KEY_SECOND) ? UNLOCKED : DISABLED;
				end
			end
			UNLOCKED: begin
				if (key_wr) begin
					lock_nxt = LOCKED;
				end
			end
			DISABLED: lock_nxt = DISABLED;
			default: lock_nxt = DISABLED;
		endcase
		if (bad_access && lock_r != DISABLED) begin
			lock_nxt = DISABLED;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= LOCKED;
		end else begin
			lock_r <= lock_nxt;
		end
	end

	// Pure decode, so polling cannot disturb a half-written key
	wire logic [7:0] key_status = (lock_r == LOCKED) ? ST_LOCKED :
		(lock_r == FIRST_KEY) ? ST_FIRST :
		(lock_r == UNLOCKED) ? ST_UNLOCKED : ST_DISABLED;

	// Transfer handshake toward the oscillator domain
	logic ack_meta_r;
	logic ack_sync_r;
	logic [1:0] strobe_cnt_r;
	logic is_rd_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_meta_r <= 1'b0;
			ack_sync_r <= 1'b0;
		end else begin
			ack_meta_r <= int_ack;
			ack_sync_r <= ack_meta_r;
		end
	end

	wire logic [1:0] strobe_last = short_r ? STROBE_SHORT_LAST : STROBE_LONG_LAST;
	wire logic strobe_done = strobe_cnt_r == strobe_last;
	// Request stays up until both the width and the return ack are seen
	wire logic req_done = xfer_r == X_REQ && strobe_done && ack_sync_r;
	wire logic xfer_end = xfer_r == X_DROP && !ack_sync_r;
	// Only capture and alarm bytes step on; control and RAM slots stay put
	function automatic logic steps_on(input logic [3:0] sel);
		return (sel <= SEL_CAPTURE_LAST) || (sel >= SEL_ALARM_FIRST && sel <= SEL_LAST_AUTOINC);
	endfunction
	wire logic sel_autoinc = steps_on(sel_r);

	always_comb begin
		xfer_nxt = xfer_r;
		case (xfer_r)
			X_IDLE: begin
				if (start_rd || start_wr) begin
					xfer_nxt = X_REQ;
				end
			end
			X_REQ: begin
				if (req_done) begin
					xfer_nxt = X_DROP;
				end
			end
			// Busy holds until the core has let go of its ack
			X_DROP: begin
				if (xfer_end) begin
					xfer_nxt = X_IDLE;
				end
			end
			default: xfer_nxt = X_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_r <= X_IDLE;
			strobe_cnt_r <= 2'h0;
			is_rd_r <= 1'b0;
		end else begin
			xfer_r <= xfer_nxt;
			if (xfer_r == X_REQ && !strobe_done) begin
				strobe_cnt_r <= strobe_cnt_r + 2'h1;
			end else if (xfer_r == X_IDLE) begin
				strobe_cnt_r <= 2'h0;
			end
			if (start_rd || start_wr) begin
				is_rd_r <= start_rd;
			end
		end
	end

	// Strobe to the core; registered so the port is glitch free
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			int_req <= '0;
		end else begin
			if (start_rd || start_wr) begin
				int_req.addr <= req_sel;
				int_req.wdata <= sfr_wdata;
				int_req.rd <= start_rd;
				int_req.wr <= start_wr;
			end else if (req_done) begin
				int_req.rd <= 1'b0;
				int_req.wr <= 1'b0;
			end
		end
	end

	// Port registers with no reset: contents survive a device reset
	always_ff @(posedge mclk) begin
		if (ok_access && adr_wr) begin
			auto_read_enable_r <= sfr_wdata[BIT_AUTO_READ_ENABLE];
			short_r <= sfr_wdata[BIT_SHORT];
		end
		if (ok_access && adr_wr && !busy) begin
			sel_r <= sfr_wdata[3:0];
		end else if (xfer_end && sel_autoinc) begin
			sel_r <= sel_r + 4'h1;
		end
		if (start_wr) begin
			data_r <= sfr_wdata;
		end else if (req_done && is_rd_r) begin
			// Taken as the request drops, while the core still holds ack and data
			data_r <= int_rdata;
		end
	end

	// Supply comparator set wins over a software clear
	always_ff @(posedge mclk) begin
		if (backup_above_core) begin
			vreg_r <= 1'b1;
		end else if (ok_access && adr_wr) begin
			vreg_r <= sfr_wdata[BIT_VREG];
		end
	end

	wire logic [7:0] adr_view = {busy, auto_read_enable_r, vreg_r, short_r, sel_r};
	wire logic [7:0] rd_mux = (hit_key) ? key_status :
		(hit_adr && unlocked) ? adr_view :
		(hit_dat && unlocked) ? data_r : RDATA_RESET;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= RDATA_RESET;
			backup_regulator_force <= 1'b0;
		end else begin
			if (sfr_rd) begin
				sfr_rdata <= rd_mux;
			end
			backup_regulator_force <= vreg_r === 1'b1;
		end
	end

	// Missing clock detector: counts system clocks between osc edges
	logic osc_prev_r;
	logic [9:0] stuck_cnt_r;
	wire logic osc_moved = slow_osc_clock != osc_prev_r;
	// Saturating past the limit makes the flag a one-shot per stall
	wire logic stuck_over = stuck_cnt_r > MISSING_CYCLES;
	wire logic fail_now = missing_clock_enable && !stuck_over
		&& (stuck_cnt_r == MISSING_CYCLES) && !osc_moved;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_prev_r <= 1'b0;
			stuck_cnt_r <= 10'h000;
			osc_event <= '0;
		end else begin
			osc_prev_r <= slow_osc_clock;
			if (!missing_clock_enable || osc_moved) begin
				stuck_cnt_r <= 10'h000;
			end else if (!stuck_over) begin
				stuck_cnt_r <= stuck_cnt_r + 10'h001;
			end
			// One shared pulse; the enables only mask the side effects
			osc_event.clock_fail_set <= fail_now;
			osc_event.wake_request <= fail_now;
			osc_event.clock_irq <= fail_now && irq_enable;
			osc_event.reset_request <= fail_now && reset_source_enable;
		end
	end
endmodule // rtc_locked_indirect_port

`default_nettype wire

/* File: test/rtc_core_model.sv */
// Behavioural clock core behind the access port
`timescale 1ns/100ps
`default_nettype none
module rtc_core_model (
	input wire logic mclk,
	input wire rtc_port_pkg::int_req_type int_req,
	input wire logic [3:0] dly,
	output logic int_ack = 1'b0,
	output logic [7:0] int_rdata = 8'h00
);
	logic [7:0] mem [16];
	logic [3:0] n = 4'h0;
	wire logic req = int_req.rd || int_req.wr;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = {4'h5, 4'(i)};
		end
	end
	// Slow answers via dly; data is junk once ack drops
	always @(posedge mclk) begin
		if (req && !int_ack) begin
			n <= n + 4'h1;
			if (n >= dly) begin
				n <= 4'h0;
				int_ack <= 1'b1;
				// Oscillator control slot reports a valid clock at once
				int_rdata <= mem[int_req.addr] | ((int_req.addr == 4'h7) ? 8'h10 : 8'h00);
				if (int_req.wr) begin
					mem[int_req.addr] <= int_req.wdata;
				end
			end
		end else if (!req && int_ack) begin
			int_ack <= 1'b0;
			int_rdata <= ~int_rdata;
		end
	end
endmodule // rtc_core_model
`default_nettype wire

/* File: test/rtc_locked_indirect_port_sva.sv */
// Checker for the clock access port
`timescale 1ns/100ps
`default_nettype none
module rtc_port_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire rtc_port_pkg::int_req_type int_req,
	input wire logic backup_above_core,
	input wire logic backup_regulator_force,
	input wire logic slow_osc_clock,
	input wire logic missing_clock_enable,
	input wire rtc_port_pkg::osc_event_type osc_event
);
	import rtc_port_pkg::*;
	logic osc_r;
	logic [9:0] cnt_r;
	// Cycles of a stall seen while the detector is on
	always_ff @(posedge mclk) begin
		osc_r <= slow_osc_clock;
		cnt_r <= (!missing_clock_enable || slow_osc_clock != osc_r) ? 10'h000 : cnt_r + 10'h001;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	key_code_a: assert property (sfr_rd && sfr_addr == SFR_KEY |=> sfr_rdata <= ST_DISABLED)
		else $error("key code range");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved");
	req_excl_a: assert property (!(int_req.rd && int_req.wr))
		else $error("read with write");
	vreg_set_a: assert property (backup_above_core |-> ##[1:4] backup_regulator_force)
		else $error("regulator not forced");
	fail_pulse_a: assert property (osc_event.clock_fail_set |=> !osc_event.clock_fail_set)
		else $error("fail pulse long");
	event_gate_a: assert property (|osc_event[1:0] |-> osc_event.clock_fail_set)
		else $error("event without fail");
	mcd_off_a: assert property (!missing_clock_enable [*3] |=> !osc_event.clock_fail_set)
		else $error("fail while off");
	mcd_time_a: assert property (osc_event.clock_fail_set |-> cnt_r > 10'h1F4 && cnt_r < 10'h1FE)
		else $error("fail mistimed");
	cover property (int_req.rd);
	cover property (int_req.wr);
	cover property (osc_event.clock_irq);
	cover property (osc_event.reset_request);
endmodule // rtc_port_sva
bind rtc_locked_indirect_port rtc_port_sva chk (.mclk, .nrst, .sfr_addr, .sfr_rd, .sfr_rdata,
	.int_req, .backup_above_core, .backup_regulator_force, .slow_osc_clock,
	.missing_clock_enable, .osc_event);
`default_nettype wire

/* File: test/rtc_locked_indirect_port_tb.sv */
// Self-checking bench for the clock access port
`timescale 1ns/100ps
`default_nettype none
module rtc_locked_indirect_port_tb;
	import rtc_port_pkg::*;
	logic mclk, nrst = 1'b0, wr = 1'b0, rd = 1'b0, bac = 1'b0, osc = 1'b0, mce = 1'b0;
	logic ire = 1'b0, rse = 1'b0, run = 1'b1, ack, fv;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, crd, v;
	logic [3:0] dly = 4'h0;
	int_req_type req;
	osc_event_type ev;
	int bad_count = 0, n_tests = 0;
	int osc_cnt = 0;
	rtc_locked_indirect_port dut (.mclk, .nrst, .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_rdata(rdata), .int_req(req), .int_rdata(crd), .int_ack(ack),
		.backup_above_core(bac), .backup_regulator_force(fv), .slow_osc_clock(osc),
		.missing_clock_enable(mce), .irq_enable(ire), .reset_source_enable(rse), .osc_event(ev));
	rtc_core_model core (.mclk, .int_req(req), .dly, .int_ack(ack), .int_rdata(crd));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Halts when run drops, like a stalled crystal; toggles every 152 clocks
	always @(posedge mclk) begin
		osc_cnt <= (osc_cnt == 151) ? 0 : osc_cnt + 1;
		if (run && osc_cnt == 151) begin
			osc <= ~osc;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task bw(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task br(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task kr(input logic [7:0] a, input logic [7:0] e);
		br(a);
		chk(v, e);
	endtask
	// Bounded poll so a stuck transfer cannot hang
	task idle;
		br(SFR_ADR_CTL);
		for (int i = 0; i < 20 && v[BIT_BUSY] !== 1'b0; i++) br(SFR_ADR_CTL);
		chk(v & 8'h80, 8'h00);
	endtask
	task end_sim;
		$display("%0d checks, %0d wrong", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task t_lock;
		kr(SFR_KEY, ST_LOCKED);
		bw(SFR_KEY, KEY_FIRST);
		kr(SFR_KEY, ST_FIRST);
		bw(SFR_KEY, KEY_SECOND);
		kr(SFR_KEY, ST_UNLOCKED);
		bw(SFR_KEY, 8'h00);
		kr(SFR_KEY, ST_LOCKED);
		bw(SFR_KEY, KEY_FIRST);
		bw(SFR_KEY, KEY_SECOND);
		$display("lock done");
	endtask
	task t_auto;
		dly <= 4'h5;
		bw(SFR_ADR_CTL, 8'hDD);
		br(SFR_ADR_CTL);
		chk(v & 8'h80, 8'h80);
		idle;
		kr(SFR_DATA, 8'h5D);
		idle;
		kr(SFR_DATA, 8'h5E);
		idle;
		kr(SFR_ADR_CTL, 8'h5E);
		dly <= 4'h0;
		$display("auto done");
	endtask
	task t_write;
		int n;
		bw(SFR_ADR_CTL, 8'h01);
		bw(SFR_DATA, 8'hA7);
		for (int i = 0; i < 8 && req.wr !== 1'b1; i++) @(negedge mclk);
		n = 0;
		while (req.wr === 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		chk(8'(n), 8'h04);
		idle;
		chk(core.mem[1], 8'hA7);
		kr(SFR_DATA, 8'hA7);
		kr(SFR_ADR_CTL, 8'h02);
		@(posedge mclk);
		bac <= 1'b1;
		repeat (4) @(posedge mclk);
		kr(SFR_ADR_CTL, 8'h22);
		chk({7'h00, fv}, 8'h01);
		@(posedge mclk);
		bac <= 1'b0;
		$display("write done");
	endtask
	task stall(input logic i, input logic r, input logic [7:0] e);
		@(posedge mclk);
		mce <= 1'b1;
		ire <= i;
		rse <= r;
		run <= 1'b0;
		for (int k = 0; k < 700 && ev.clock_fail_set !== 1'b1; k++) @(negedge mclk);
		chk({4'h0, ev}, e);
		@(posedge mclk);
		mce <= 1'b0;
		ire <= 1'b0;
		rse <= 1'b0;
		run <= 1'b1;
	endtask
	task t_mcd;
		stall(1'b1, 1'b0, 8'h0E);
		stall(1'b0, 1'b1, 8'h0D);
		$display("detector done");
	endtask
	task t_osc;
		@(posedge mclk);
		mce <= 1'b0;
		bw(SFR_ADR_CTL, 8'h07);
		bw(SFR_DATA, 8'hE0);
		idle;
		kr(SFR_ADR_CTL, 8'h07);
		bw(SFR_ADR_CTL, 8'h87);
		idle;
		kr(SFR_DATA, 8'hF0);
		bw(SFR_DATA, 8'h20);
		idle;
		chk(core.mem[7], 8'h20);
		$display("oscillator done");
	endtask
	task t_bad;
		bw(SFR_KEY, 8'h00);
		bw(SFR_KEY, KEY_FIRST);
		bw(SFR_KEY, 8'h12);
		kr(SFR_KEY, ST_DISABLED);
		bw(SFR_KEY, KEY_FIRST);
		kr(SFR_KEY, ST_DISABLED);
		kr(SFR_ADR_CTL, 8'h00);
		$display("bad key done");
	endtask
	task t_reset;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		kr(SFR_KEY, ST_LOCKED);
		bw(SFR_KEY, KEY_FIRST);
		bw(SFR_KEY, KEY_SECOND);
		kr(SFR_ADR_CTL, 8'h07);
		kr(SFR_DATA, 8'h20);
		bw(SFR_ADR_CTL, 8'h82);
		br(SFR_DATA);
		kr(SFR_KEY, ST_DISABLED);
		$display("reset done");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		t_lock;
		t_auto;
		t_write;
		t_mcd;
		t_osc;
		t_bad;
		t_reset;
		end_sim;
	end
	// Run needs about 1200 cycles; allow over twenty times that
	initial begin
		#3000000;
		bad_count++;
		end_sim;
	end
endmodule // rtc_locked_indirect_port_tb
`default_nettype wire
